// ### gfx_pkg.sv
// Constants and carrier types for the planar graphics write/read datapath.
package gfx_pkg;

	// Register ports on the host I/O space.
	localparam logic [15:0] PORT_INDEX = 16'h03CE;
	localparam logic [15:0] PORT_DATA = 16'h03CF;

	// Indexes reached through the data port.
	localparam logic [3:0] IDX_FILL_VALUE = 4'h0;
	localparam logic [3:0] IDX_FILL_ENABLE = 4'h1;
	localparam logic [3:0] IDX_MATCH_VALUE = 4'h2;
	localparam logic [3:0] IDX_ROTATE_OP = 4'h3;
	localparam logic [3:0] IDX_READ_PLANE = 4'h4;
	localparam logic [3:0] IDX_ACCESS_MODE = 4'h5;
	localparam logic [3:0] IDX_WINDOW_CHAIN = 4'h6;
	localparam logic [3:0] IDX_MATCH_PART = 4'h7;
	localparam logic [3:0] IDX_BIT_PROTECT = 4'h8;

	// Field positions in access_mode_control.
	localparam int AM_LOAD_256 = 6;
	localparam int AM_INTERLEAVE = 5;
	localparam int AM_ODD_EVEN = 4;
	localparam int AM_COMPARE = 3;
	// Field positions in rotate_and_logic_op and window_and_chain_control.
	localparam int RO_OP_LSB = 3;
	localparam int WC_WIN_LSB = 2;
	localparam int WC_CHAIN = 1;

	// Write modes and logic functions.
	localparam logic [1:0] WMODE_0 = 2'h0;
	localparam logic [1:0] WMODE_1 = 2'h1;
	localparam logic [1:0] WMODE_2 = 2'h2;
	localparam logic [1:0] WMODE_3 = 2'h3;
	localparam logic [1:0] OP_PASS = 2'h0;
	localparam logic [1:0] OP_AND = 2'h1;
	localparam logic [1:0] OP_OR = 2'h2;
	localparam logic [1:0] OP_XOR = 2'h3;

	// Processor memory windows: base and the bits that must match it.
	localparam logic [19:0] WIN0_BASE = 20'hA0000;
	localparam logic [19:0] WIN0_MASK = 20'hE0000;
	localparam logic [19:0] WIN1_BASE = 20'hA0000;
	localparam logic [19:0] WIN1_MASK = 20'hF0000;
	localparam logic [19:0] WIN2_BASE = 20'hB0000;
	localparam logic [19:0] WIN2_MASK = 20'hF8000;
	localparam logic [19:0] WIN3_BASE = 20'hB8000;
	localparam logic [19:0] WIN3_MASK = 20'hF8000;

	// Value of every register after reset.
	localparam logic [7:0] REG_RESET = 8'h00;

	typedef struct packed {
		logic [15:0] addr;
		logic wr;
		logic rd;
		logic [7:0] wdata;
	} io_req_t;

	typedef struct packed {
		logic [19:0] addr;
		logic wr;
		logic rd;
		logic [7:0] wdata;
	} mem_req_t;

	typedef struct packed {
		logic [15:0] addr;
		logic [3:0] we;
		logic rd;
		logic [31:0] wdata;
	} plane_req_t;

endpackage : gfx_pkg

// ### gfx_datapath.sv
// Planar graphics datapath between host cycles and four display planes.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module gfx_datapath (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Register ports.
	input wire gfx_pkg::io_req_t io_req_i,
	output logic [7:0] io_rdata_o,
	// Processor memory cycles.
	input wire gfx_pkg::mem_req_t mem_req_i,
	output logic mem_busy_o,
	output logic [7:0] mem_rdata_o,
	output logic mem_rvalid_o,
	// Sequencer chain mode bit.
	input wire logic seq_chain_i,
	// Display planes.
	output gfx_pkg::plane_req_t plane_req_o,
	input wire logic [31:0] plane_rdata_i,
	// Display fetch and shift registers.
	input wire logic disp_load_i,
	input wire logic [31:0] disp_data_i,
	output logic [3:0] pixel_nibble_o,
	output logic [7:0] pixel_byte_o,
	output logic pixel_byte_valid_o
);
	import gfx_pkg::*;

	typedef struct packed {
		logic [3:0] ptr;
		logic [3:0] fill;
		logic [3:0] fill_en;
		logic [3:0] match;
		logic [4:0] rotop;
		logic [1:0] rmap;
		logic [7:0] amode;
		logic [3:0] wchain;
		logic [3:0] part;
		logic [7:0] protect;
		logic [31:0] latch;
		logic [7:0] io_rdata;
		logic [7:0] mem_rdata;
		logic mem_rvalid;
		plane_req_t preq;
		logic rd_wait;
		logic [1:0] rd_plane;
		logic rd_compare;
		logic [31:0] sr;
		logic [3:0] nib_prev;
		logic phase;
		logic [7:0] pix_byte;
		logic pix_valid;
		logic [3:0] pix_nib;
	} state_t;

	state_t s;
	state_t next_s;

	////////////////////////////////////////////////////////////////////////
	// Write data shaping.

	logic [1:0] wmode;
	logic [1:0] op;
	logic [15:0] rot_wide;
	logic [7:0] rot;
	logic [7:0] eff_mask;
	logic [31:0] wr_data;
	logic [31:0] match_bits;
	logic [7:0] cmp_byte;

	assign wmode = s.amode[1:0];
	assign op = s.rotop[RO_OP_LSB +: 2];
	assign rot_wide = {mem_req_i.wdata, mem_req_i.wdata} >> s.rotop[2:0];
	assign rot = rot_wide[7:0];
	// In mode 3 the rotated byte narrows the mask instead of being data.
	assign eff_mask = (wmode == WMODE_3) ? (rot & s.protect)
		: s.protect;

	genvar p;
	for (p = 0; p < 4; p++) begin : g_plane
		logic [7:0] src;
		logic [7:0] lat;
		logic [7:0] alu;
		assign lat = s.latch[p*8 +: 8];
		always_comb begin
			case (wmode)
				WMODE_0: src = s.fill_en[p] ? {8{s.fill[p]}}
					: rot;
				WMODE_2: src = {8{mem_req_i.wdata[p]}};
				default: src = {8{s.fill[p]}};
			endcase
			case (op)
				OP_AND: alu = src & lat;
				OP_OR: alu = src | lat;
				OP_XOR: alu = src ^ lat;
				default: alu = src;
			endcase
		end
		// Positions cleared in the mask carry the latch back, so memory keeps them.
		assign wr_data[p*8 +: 8] = (wmode == WMODE_1) ? lat
			: ((alu & eff_mask) | (lat & ~eff_mask));
		assign match_bits[p*8 +: 8] = {8{~s.part[p]}}
			| ~(plane_rdata_i[p*8 +: 8] ^ {8{s.match[p]}});
	end

	assign cmp_byte = match_bits[7:0] & match_bits[15:8]
		& match_bits[23:16] & match_bits[31:24];

	////////////////////////////////////////////////////////////////////////
	// Processor address decode.

	logic hit;
	logic [19:0] off;
	logic [15:0] paddr;
	logic odd_even;
	logic [3:0] pmask;
	logic [1:0] rplane;

	always_comb begin
		case (s.wchain[WC_WIN_LSB +: 2])
			2'h0: begin
				hit = (mem_req_i.addr & WIN0_MASK) == WIN0_BASE;
				off = mem_req_i.addr & ~WIN0_MASK;
			end
			2'h1: begin
				hit = (mem_req_i.addr & WIN1_MASK) == WIN1_BASE;
				off = mem_req_i.addr & ~WIN1_MASK;
			end
			2'h2: begin
				hit = (mem_req_i.addr & WIN2_MASK) == WIN2_BASE;
				off = mem_req_i.addr & ~WIN2_MASK;
			end
			default: begin
				hit = (mem_req_i.addr & WIN3_MASK) == WIN3_BASE;
				off = mem_req_i.addr & ~WIN3_MASK;
			end
		endcase
		// Chaining trades address bit 0 for offset bit 16, the top bit of window 0 only.
		paddr = s.wchain[WC_CHAIN] ? {off[15:1], off[16]}
			: off[15:0];
		odd_even = s.amode[AM_ODD_EVEN] | s.wchain[WC_CHAIN];
		pmask = !odd_even ? 4'hF
			: (mem_req_i.addr[0] ? 4'hA : 4'h5);
		if (seq_chain_i)
			rplane = mem_req_i.addr[1:0];
		else if (odd_even)
			rplane = {s.rmap[1], mem_req_i.addr[0]};
		else
			rplane = s.rmap;
	end

	////////////////////////////////////////////////////////////////////////
	// Register file, memory cycles and shift registers.

	logic take_rd;
	logic take_wr;
	logic [31:0] load_word;
	logic [3:0] msbs;

	assign mem_busy_o = s.preq.rd | s.rd_wait;
	assign take_rd = mem_req_i.rd & hit & ~mem_busy_o;
	assign take_wr = mem_req_i.wr & hit & ~mem_busy_o & ~mem_req_i.rd;
	assign msbs = {s.sr[31], s.sr[23], s.sr[15], s.sr[7]};

	always_comb begin
		logic [7:0] d;
		logic [7:0] q0;
		logic [7:0] q1;
		logic [7:0] q2;
		logic [7:0] q3;
		d = io_req_i.wdata;
		q0 = disp_data_i[7:0];
		q1 = disp_data_i[15:8];
		q2 = disp_data_i[23:16];
		q3 = disp_data_i[31:24];
		next_s = s;
		// Register port writes.
		if (io_req_i.wr && io_req_i.addr == PORT_INDEX)
			next_s.ptr = d[3:0];
		if (io_req_i.wr && io_req_i.addr == PORT_DATA) begin
			case (s.ptr)
				IDX_FILL_VALUE: next_s.fill = d[3:0];
				IDX_FILL_ENABLE: next_s.fill_en = d[3:0];
				IDX_MATCH_VALUE: next_s.match = d[3:0];
				IDX_ROTATE_OP: next_s.rotop = d[4:0];
				IDX_READ_PLANE: next_s.rmap = d[1:0];
				IDX_ACCESS_MODE: next_s.amode = d & 8'h7B;
				IDX_WINDOW_CHAIN: next_s.wchain = d[3:0];
				IDX_MATCH_PART: next_s.part = d[3:0];
				IDX_BIT_PROTECT: next_s.protect = d;
				default: ;
			endcase
		end
		// Register port reads; extension indexes read as zero here.
		if (io_req_i.rd) begin
			if (io_req_i.addr == PORT_INDEX)
				next_s.io_rdata = {4'h0, s.ptr};
			else if (io_req_i.addr == PORT_DATA) begin
				case (s.ptr)
					IDX_FILL_VALUE: next_s.io_rdata = {4'h0, s.fill};
					IDX_FILL_ENABLE: next_s.io_rdata = {4'h0, s.fill_en};
					IDX_MATCH_VALUE: next_s.io_rdata = {4'h0, s.match};
					IDX_ROTATE_OP: next_s.io_rdata = {3'h0, s.rotop};
					IDX_READ_PLANE: next_s.io_rdata = {6'h00, s.rmap};
					IDX_ACCESS_MODE: next_s.io_rdata = s.amode;
					IDX_WINDOW_CHAIN: next_s.io_rdata = {4'h0, s.wchain};
					IDX_MATCH_PART: next_s.io_rdata = {4'h0, s.part};
					IDX_BIT_PROTECT: next_s.io_rdata = s.protect;
					default: next_s.io_rdata = 8'h00;
				endcase
			end else
				next_s.io_rdata = 8'h00;
		end
		// Plane cycles: one issue cycle, data comes back one cycle later.
		next_s.preq.rd = take_rd;
		next_s.preq.we = take_wr ? pmask : 4'h0;
		next_s.rd_wait = s.preq.rd;
		next_s.mem_rvalid = s.rd_wait;
		if (take_rd | take_wr)
			next_s.preq.addr = paddr;
		if (take_wr)
			next_s.preq.wdata = wr_data;
		if (take_rd) begin
			next_s.rd_plane = rplane;
			next_s.rd_compare = s.amode[AM_COMPARE];
		end
		if (s.rd_wait) begin
			next_s.latch = plane_rdata_i;
			if (s.rd_compare)
				next_s.mem_rdata = cmp_byte;
			else
				next_s.mem_rdata = plane_rdata_i[s.rd_plane*8 +: 8];
		end
		// Shift register load format; MSB leaves first in every format.
		if (disp_load_i) begin
			if (s.amode[AM_INTERLEAVE] && !s.amode[AM_LOAD_256])
				next_s.sr = {
					q1[7], q1[5], q1[3], q1[1], q3[7], q3[5], q3[3], q3[1],
					q1[6], q1[4], q1[2], q1[0], q3[6], q3[4], q3[2], q3[0],
					q0[7], q0[5], q0[3], q0[1], q2[7], q2[5], q2[3], q2[1],
					q0[6], q0[4], q0[2], q0[0], q2[6], q2[4], q2[2], q2[0]
				};
			else
				next_s.sr = disp_data_i;
			next_s.phase = 1'b0;
		end else begin
			for (int i = 0; i < 4; i++)
				next_s.sr[i*8 +: 8] = {s.sr[i*8 +: 7], 1'b0};
			next_s.phase = ~s.phase;
		end
		next_s.pix_nib = msbs;
		// In 256-colour load two nibbles pair into one pixel byte.
		next_s.nib_prev = msbs;
		next_s.pix_valid = s.amode[AM_LOAD_256] & s.phase;
		if (s.amode[AM_LOAD_256] && s.phase)
			next_s.pix_byte = {s.nib_prev, msbs};
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i)
			s <= '0;
		else
			s <= next_s;
	end

	assign io_rdata_o = s.io_rdata;
	assign mem_rdata_o = s.mem_rdata;
	assign mem_rvalid_o = s.mem_rvalid;
	assign plane_req_o = s.preq;
	assign pixel_nibble_o = s.pix_nib;
	assign pixel_byte_o = s.pix_byte;
	assign pixel_byte_valid_o = s.pix_valid;

	////////////////////////////////////////////////////////////////////////
	// Checks.

	a_index_select: assert property (
		@(posedge clk_i) disable iff (!rst_b_i)
		io_req_i.wr && io_req_i.addr == PORT_INDEX && !io_req_i.rd
		|=> s.ptr == $past(io_req_i.wdata[3:0]))
		else $error("index pointer not loaded");
	a_fill_mode0: assert property (
		@(posedge clk_i) disable iff (!rst_b_i)
		take_wr && wmode == WMODE_0 && s.fill_en[0] && s.protect == 8'hFF
		&& op == OP_PASS |=> plane_req_o.wdata[7:0] == {8{$past(s.fill[0])}})
		else $error("fill value not written in mode 0");
	a_rotate_mode0: assert property (
		@(posedge clk_i) disable iff (!rst_b_i)
		take_wr && wmode == WMODE_0 && !s.fill_en[1] && s.protect == 8'hFF
		&& op == OP_PASS |=> plane_req_o.wdata[15:8] == $past(rot))
		else $error("rotated data not written");
	a_fill_mode2: assert property (
		@(posedge clk_i) disable iff (!rst_b_i)
		take_wr && wmode == WMODE_2 && s.protect == 8'hFF && op == OP_PASS
		|=> plane_req_o.wdata[7:0] == {8{$past(mem_req_i.wdata[0])}})
		else $error("data bit not replicated in mode 2");
	a_copy_mode1: assert property (
		@(posedge clk_i) disable iff (!rst_b_i)
		take_wr && wmode == WMODE_1 |=> plane_req_o.wdata == $past(s.latch))
		else $error("latches not copied in mode 1");
	a_mask_keeps: assert property (
		@(posedge clk_i) disable iff (!rst_b_i)
		take_wr && s.protect == 8'h00 |=> plane_req_o.wdata == $past(s.latch))
		else $error("masked bits changed");
	a_read_latch: assert property (
		@(posedge clk_i) disable iff (!rst_b_i)
		take_rd |-> ##2 s.rd_wait ##1 (s.latch == $past(plane_rdata_i)
		&& mem_rvalid_o))
		else $error("read did not load latches");
	// A read holds the port for two cycles so the latches load in order.
	a_busy_read: assert property (
		@(posedge clk_i) disable iff (!rst_b_i)
		take_rd |=> mem_busy_o ##1 mem_busy_o ##1 !mem_busy_o)
		else $error("read busy window wrong");
	a_rvalid_pulse: assert property (
		@(posedge clk_i) disable iff (!rst_b_i)
		mem_rvalid_o |=> !mem_rvalid_o)
		else $error("read valid held for two cycles");
	a_compare_none: assert property (
		@(posedge clk_i) disable iff (!rst_b_i)
		take_rd && s.amode[AM_COMPARE] && s.part == 4'h0
		|-> ##3 mem_rdata_o == 8'hFF)
		else $error("excluded planes still compared");
	a_window_miss: assert property (
		@(posedge clk_i) disable iff (!rst_b_i)
		mem_req_i.wr && s.wchain[3:2] == 2'h3 && mem_req_i.addr[19:16] == 4'hA
		|=> plane_req_o.we == 4'h0)
		else $error("write outside window accepted");
	a_odd_even_wr: assert property (
		@(posedge clk_i) disable iff (!rst_b_i)
		take_wr && s.amode[AM_ODD_EVEN] && !mem_req_i.addr[0]
		|=> plane_req_o.we == 4'h5)
		else $error("even address reached odd planes");
	a_pixel_pair: assert property (
		@(posedge clk_i) disable iff (!rst_b_i)
		pixel_byte_valid_o |-> !$past(pixel_byte_valid_o))
		else $error("pixel bytes not paired");

endmodule : gfx_datapath

// ### plane_store_model.sv
// Behavioural four-plane display memory facing the datapath's plane port.
`timescale 1ns/1ps
module plane_store_model #(
	parameter logic [31:0] INIT = 32'h0F3C_A5E1
) (
	// Clock.
	input wire logic clk_i,
	// Plane requests and read data.
	input wire gfx_pkg::plane_req_t plane_req_i,
	output logic [31:0] plane_rdata_o
);
	import gfx_pkg::*;
	logic [31:0] mem [16];
	logic rd_q = 1'b0;
	logic [31:0] last = 32'h0000_0000;
	initial begin
		for (int i = 0; i < 16; i++) begin
			mem[i] = INIT;
		end
	end
	////////////////////////////////////////////////
	// Data stands only in the read cycle and the next; otherwise the lines
	// flip each cycle so that a late sample cannot pass by luck.
	always @(posedge clk_i) begin
		rd_q <= plane_req_i.rd;
		last <= ~plane_rdata_o;
		for (int p = 0; p < 4; p++) begin
			if (plane_req_i.we[p]) begin
				mem[plane_req_i.addr[3:0]][p*8 +: 8] <= plane_req_i.wdata[p*8 +: 8];
			end
		end
	end
	assign plane_rdata_o = (plane_req_i.rd || rd_q) ?
		mem[plane_req_i.addr[3:0]] : last;
endmodule : plane_store_model

// ### gfx_datapath_tb.sv
// Self-checking bench for the planar graphics datapath.
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fails++; \
	$display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module gfx_datapath_tb;
	import gfx_pkg::*;
	localparam logic [31:0] INIT = 32'h0F3C_A5E1;
	logic clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	io_req_t io_req = '0;
	mem_req_t mem_req = '0;
	logic seq_chain = 1'b0;
	logic disp_load = 1'b0;
	logic [31:0] disp_data = '0;
	logic [7:0] io_rdata, mem_rdata, pix_byte;
	logic mem_busy, mem_rvalid, pix_valid;
	plane_req_t plane_req;
	logic [31:0] plane_rdata;
	logic [3:0] nibble;
	logic [7:0] r_fill, r_fen, r_rot, r_mask;
	int checks = 0;
	int fails = 0;
	always #2 clk_i = ~clk_i;
	gfx_datapath dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .io_req_i(io_req),
		.io_rdata_o(io_rdata), .mem_req_i(mem_req), .mem_busy_o(mem_busy),
		.mem_rdata_o(mem_rdata), .mem_rvalid_o(mem_rvalid),
		.seq_chain_i(seq_chain), .plane_req_o(plane_req),
		.plane_rdata_i(plane_rdata), .disp_load_i(disp_load),
		.disp_data_i(disp_data), .pixel_nibble_o(nibble),
		.pixel_byte_o(pix_byte), .pixel_byte_valid_o(pix_valid));
	plane_store_model #(.INIT(INIT)) planes (.clk_i(clk_i),
		.plane_req_i(plane_req), .plane_rdata_o(plane_rdata));
	////////////////////////////////////////////////
	task automatic give_verdict();
		$display("checks=%0d fails=%0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : give_verdict
	task automatic io_op(input logic [15:0] a, input logic w, logic [7:0] d);
		@(negedge clk_i);
		io_req = '{a, w, !w, d};
		@(negedge clk_i);
		io_req = '0;
	endtask : io_op
	task automatic setr(input logic [3:0] i, input logic [7:0] d);
		io_op(PORT_INDEX, 1'b1, {4'h0, i});
		io_op(PORT_DATA, 1'b1, d);
	endtask : setr
	task automatic getr(input logic [3:0] i, output logic [7:0] v);
		io_op(PORT_INDEX, 1'b1, {4'h0, i});
		io_op(PORT_DATA, 1'b0, 8'h00);
		@(negedge clk_i);
		v = io_rdata;
	endtask : getr
	task automatic cfg(input logic [7:0] f, e, ro, md, mk);
		r_fill = f;
		r_fen = e;
		r_rot = ro;
		r_mask = mk;
		setr(IDX_FILL_VALUE, f);
		setr(IDX_FILL_ENABLE, e);
		setr(IDX_ROTATE_OP, ro);
		setr(IDX_ACCESS_MODE, md);
		setr(IDX_BIT_PROTECT, mk);
	endtask : cfg
	task automatic mem_rd(input logic [19:0] a, output logic [7:0] v);
		int n;
		@(negedge clk_i);
		mem_req = '{a, 1'b0, 1'b1, 8'h00};
		@(negedge clk_i);
		mem_req = '0;
		`CHK(mem_busy, 1'b1)
		for (n = 0; n < 8 && mem_rvalid !== 1'b1; n++) @(negedge clk_i);
		if (n == 8) begin
			fails++;
			give_verdict();
		end
		v = mem_rdata;
	endtask : mem_rd
	// An out-of-window write simply finds no plane strobe within the bound.
	task automatic mem_wr(input logic [19:0] a, input logic [7:0] d,
		output logic [3:0] we, output logic [31:0] wd);
		int n;
		@(negedge clk_i);
		mem_req = '{a, 1'b1, 1'b0, d};
		@(negedge clk_i);
		mem_req = '0;
		for (n = 0; n < 4 && plane_req.we === 4'h0; n++) @(negedge clk_i);
		we = plane_req.we;
		wd = plane_req.wdata;
	endtask : mem_wr
	function automatic logic [31:0] exp_wr(input logic [1:0] md, op,
		input logic [7:0] d);
		logic [15:0] dd;
		logic [7:0] v, m, l;
		logic [31:0] r;
		dd = {d, d} >> r_rot[2:0];
		if (md == WMODE_1) return INIT;
		m = (md == WMODE_3) ? (dd[7:0] & r_mask) : r_mask;
		for (int p = 0; p < 4; p++) begin
			l = INIT[p*8 +: 8];
			case (md)
				WMODE_0: v = r_fen[p] ? {8{r_fill[p]}} : dd[7:0];
				WMODE_2: v = {8{d[p]}};
				default: v = {8{r_fill[p]}};
			endcase
			case (op)
				OP_AND: v = v & l;
				OP_OR: v = v | l;
				OP_XOR: v = v ^ l;
				default: v = v;
			endcase
			r[p*8 +: 8] = (v & m) | (l & ~m);
		end
		return r;
	endfunction : exp_wr
	////////////////////////////////////////////////
	task automatic t_regs();
		logic [7:0] v;
		for (int i = 0; i < 9; i++) begin
			getr(4'(i), v);
			`CHK(v, REG_RESET)
		end
		setr(IDX_ACCESS_MODE, 8'hFF);
		getr(IDX_ACCESS_MODE, v);
		`CHK(v, 8'h7B)
		setr(4'h9, 8'h5A);
		getr(4'h9, v);
		`CHK(v, 8'h00)
		io_op(PORT_INDEX, 1'b1, 8'hFF);
		io_op(PORT_INDEX, 1'b0, 8'h00);
		@(negedge clk_i);
		`CHK(io_rdata, 8'h0F)
		setr(IDX_ACCESS_MODE, 8'h00);
	endtask : t_regs
	task automatic t_reads();
		logic [7:0] v;
		logic [7:0] e;
		for (int p = 0; p < 4; p++) begin
			setr(IDX_READ_PLANE, 8'(p));
			mem_rd(20'hA0000, v);
			`CHK(v, INIT[p*8 +: 8])
		end
		seq_chain = 1'b1;
		mem_rd(20'hA0000, v);
		`CHK(v, INIT[7:0])
		seq_chain = 1'b0;
		setr(IDX_ACCESS_MODE, 8'h08);
		for (int k = 0; k < 5; k++) begin
			setr(IDX_MATCH_VALUE, 8'(k * 5));
			setr(IDX_MATCH_PART, 8'(4'hF >> k));
			mem_rd(20'hA0000, v);
			for (int i = 0; i < 8; i++) begin
				e[i] = 1'b1;
				for (int p = 0; p < 4; p++)
					if (p >= 4 - k) e[i] = e[i];
					else if (INIT[p*8+i] != 1'((k * 5) >> p)) e[i] = 1'b0;
			end
			`CHK(v, e)
		end
	endtask : t_reads
	task automatic t_writes();
		logic [3:0] we;
		logic [31:0] wd;
		logic [7:0] mks [3] = '{8'hF0, 8'hFF, 8'h00};
		for (int k = 0; k < 3; k++) begin
			for (int m = 0; m < 4; m++) begin
				for (int o = 0; o < 4; o++) begin
					cfg(8'h05, 8'h05, 8'(o * 10 + 1), 8'(m), mks[k]);
					mem_wr(20'hA0004, 8'h81, we, wd);
					`CHK(we, 4'hF)
					`CHK(plane_req.addr, 16'h0004)
					`CHK(wd, exp_wr(2'(m), 2'(o), 8'h81))
				end
			end
		end
	endtask : t_writes
	task automatic t_window();
		logic [3:0] we;
		logic [31:0] wd;
		logic [19:0] ins [4] = '{20'hBFFFF, 20'hAFFFF, 20'hB7FFF, 20'hB8000};
		logic [19:0] outs [4] = '{20'h9FFFF, 20'hB0000, 20'hB8000, 20'hB7FFF};
		for (int w = 0; w < 4; w++) begin
			setr(IDX_WINDOW_CHAIN, 8'(w * 4 + 1));
			mem_wr(ins[w], 8'h00, we, wd);
			`CHK(we, 4'hF)
			mem_wr(outs[w], 8'h00, we, wd);
			`CHK(we, 4'h0)
		end
		mem_wr(20'hA8000, 8'h00, we, wd);
		`CHK(we, 4'h0)
	endtask : t_window
	task automatic t_oddeven();
		logic [3:0] we;
		logic [31:0] wd;
		for (int k = 0; k < 2; k++) begin
			setr(IDX_ACCESS_MODE, k ? 8'h10 : 8'h00);
			setr(IDX_WINDOW_CHAIN, k ? 8'h00 : 8'h02);
			mem_wr(20'hA0000, 8'h00, we, wd);
			`CHK(we, 4'h5)
			mem_wr(20'hA0001, 8'h00, we, wd);
			`CHK(we, 4'hA)
		end
	endtask : t_oddeven
	task automatic t_shift();
		int n;
		int b;
		logic [7:0] hi, lo;
		setr(IDX_ACCESS_MODE, 8'h00);
		disp_data = INIT;
		disp_load = 1'b1;
		@(negedge clk_i);
		disp_load = 1'b0;
		for (int k = 0; k < 8; k++) begin
			@(negedge clk_i);
			`CHK(nibble, {INIT[31-k], INIT[23-k], INIT[15-k], INIT[7-k]})
		end
		// Interleave: planes 1 and 0 leave first, as odd and even bit pairs.
		setr(IDX_ACCESS_MODE, 8'h20);
		disp_load = 1'b1;
		@(negedge clk_i);
		disp_load = 1'b0;
		for (int k = 0; k < 8; k++) begin
			@(negedge clk_i);
			b = 2 * (k % 4);
			hi = (k < 4) ? INIT[15:8] : INIT[31:24];
			lo = (k < 4) ? INIT[7:0] : INIT[23:16];
			`CHK(nibble, {hi[7-b], hi[6-b], lo[7-b], lo[6-b]})
		end
		setr(IDX_ACCESS_MODE, 8'h40);
		disp_load = 1'b1;
		@(negedge clk_i);
		disp_load = 1'b0;
		for (n = 0; n < 4 && pix_valid !== 1'b1; n++) @(negedge clk_i);
		if (n == 4) begin
			fails++;
			give_verdict();
		end
		`CHK(pix_byte, {INIT[31], INIT[23], INIT[15], INIT[7], INIT[30], INIT[22], INIT[14], INIT[6]})
	endtask : t_shift
	initial begin
		repeat (6) @(negedge clk_i);
		rst_b_i = 1'b1;
		@(negedge clk_i);
		t_regs();
		t_reads();
		t_writes();
		t_window();
		t_oddeven();
		t_shift();
		give_verdict();
	end
endmodule : gfx_datapath_tb
